// *** rtl/fan_ramp_pkg.sv ***
`default_nettype none

package fan_ramp_pkg;

	// ==========================================================
	// Register map (word indices, byte address is four times)
	localparam logic [7:0] ACOU_IDX   = 8'h62;
	localparam logic [7:0] LOCK_IDX   = 8'h40;
	localparam logic [7:0] STATUS_IDX = 8'h41;
	localparam int         ADDR_W     = 10;

	// ==========================================================
	// Field positions
	localparam int RATE_LSB    = 0;
	localparam int RATE_W      = 3;
	localparam int EN1_BIT     = 3;
	localparam int ALIGN_BIT   = 4;
	localparam int FLOOR_LSB   = 5;
	localparam int LOCK_BIT    = 0;
	localparam int DUTY_W      = 8;
	localparam int CHANNELS    = 3;

	// ==========================================================
	// Reset values
	localparam logic [7:0] ACOU_RESET = 8'h00;
	localparam logic       LOCK_RESET = 1'b0;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ      = 10000000;
	localparam int unsigned SLOT_MS     = 200;
	localparam int unsigned SLOT_CYCLES = SLOT_MS * (CLK_HZ / 1000);
	localparam logic [7:0]  PWM_PRESCALE = 8'h27;

	// ==========================================================
	// Duty step per time slot, indexed by rate code
	localparam logic [7:0] STEP_TABLE [8] = '{
		8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30
	};

endpackage : fan_ramp_pkg

`default_nettype wire

// *** rtl/ramp_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface ramp_if;
	logic       slot_tick;
	logic       enable;
	logic [2:0] rate;
	logic [7:0] target;
	logic [7:0] duty;

	modport ctrl (output slot_tick, output enable, output rate, output target, input duty);
	modport ramp (input slot_tick, input enable, input rate, input target, output duty);
endinterface : ramp_if

`default_nettype wire

// *** rtl/duty_ramp.sv ***
`timescale 1ns/1ps
`default_nettype none

module duty_ramp (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Ramp channel
	ramp_if.ramp      rp
);

	// ==========================================================
	// Step toward target
	logic [7:0] duty;
	logic [7:0] next_duty;
	logic [7:0] step;
	logic [7:0] diff;

	assign step    = fan_ramp_pkg::STEP_TABLE[rp.rate];
	assign rp.duty = duty;

	always_comb begin
		next_duty = duty;
		diff      = 8'h00;
		if (!rp.enable) begin
			next_duty = rp.target;
		end else if (rp.slot_tick) begin
			if (rp.target > duty) begin
				diff      = rp.target - duty;
				next_duty = (diff > step) ? 8'(duty + step) : rp.target;
			end else if (rp.target < duty) begin
				diff      = duty - rp.target;
				next_duty = (diff > step) ? 8'(duty - step) : rp.target;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			duty <= 8'h00;
		end else begin
			duty <= next_duty;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	step_bound_a: assert property (
		rp.enable && rp.slot_tick && rp.target > duty && (rp.target - duty) > step
		|=> duty == 8'($past(duty) + $past(step)))
		else $error("ramp step size wrong");

	hold_slot_a: assert property (
		rp.enable && !rp.slot_tick |=> $stable(duty))
		else $error("duty moved outside a time slot");

	no_overshoot_a: assert property (
		rp.enable && rp.slot_tick && rp.target < duty |=> duty >= $past(rp.target))
		else $error("ramp overshot target");

	direct_load_a: assert property (
		!rp.enable |=> duty == $past(rp.target))
		else $error("duty not loaded directly");

endmodule : duty_ramp

`default_nettype wire

// *** rtl/pwm_wave.sv ***
`timescale 1ns/1ps
`default_nettype none

module pwm_wave (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	// Duty in, drive out
	input  wire logic [7:0] duty,
	output logic            wave
);

	// ==========================================================
	// Period counter
	logic [7:0] pre;
	logic [7:0] phase;
	logic [7:0] held;
	logic [7:0] next_pre;
	logic [7:0] next_phase;
	logic [7:0] next_held;
	logic       next_wave;

	// Duty held per period so a mid-period change cannot glitch the fan
	always_comb begin
		next_pre   = pre + 8'h01;
		next_phase = phase;
		next_held  = held;
		if (pre == fan_ramp_pkg::PWM_PRESCALE) begin
			next_pre   = 8'h00;
			next_phase = phase + 8'h01;
			if (phase == 8'hff) begin
				next_held = duty;
			end
		end
		next_wave = (phase < held);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pre   <= 8'h00;
			phase <= 8'h00;
			held  <= 8'h00;
			wave  <= 1'b0;
		end else begin
			pre   <= next_pre;
			phase <= next_phase;
			held  <= next_held;
			wave  <= next_wave;
		end
	end

endmodule : pwm_wave

`default_nettype wire

// *** rtl/fan_ramp_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

// Operation
// - With ramping on, drive output 1 steps by 1,2,3,4,8,12,24 or 48 per slot for codes 0..7.
// - A full 33% to 100% ramp takes about 35 s at code 0 down to about 0.8 s at code 7.
// - Ramping acts on drive output 1 only while its enable bit 3 is set.
// - With align bit 4 set, speed inputs 2, 3 and 4 are timed to drive output 3.
// - With align bit 4 clear, only speed inputs 3 and 4 are timed to drive output 3.
// - In automatic mode below the start threshold, output 1 runs 0% or its minimum per bit 5.
// - In automatic mode below the start threshold, output 2 runs 0% or its minimum per bit 6.
// - In automatic mode below the start threshold, output 3 runs 0% or its minimum per bit 7.
// - Once the lock bit is set the control register ignores all writes.
// - The control register sits at index 0x62 and resets to 0x00.
module fan_ramp_ctrl #(
	parameter int unsigned SLOT_CYCLES = fan_ramp_pkg::SLOT_CYCLES
) (
	// Clock and reset
	input  wire logic                              sys_clk,
	input  wire logic                              rstn,
	// APB slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [fan_ramp_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// Automatic control inputs
	input  wire logic                              auto_mode,
	input  wire logic [2:0]                        below_threshold,
	input  wire logic [2:0][7:0]                   computed_duty,
	input  wire logic [2:0][7:0]                   minimum_duty,
	// Speed sense pins
	input  wire logic                              speed_sense_in2,
	input  wire logic                              speed_sense_in3,
	input  wire logic                              speed_sense_in4,
	// Fan drive pins and measurement
	output logic                                   fan_drive_out1,
	output logic                                   fan_drive_out2,
	output logic                                   fan_drive_out3,
	output logic      [2:0]                        speed_pulse
);

	// ==========================================================
	// Register bus
	logic [7:0]  acoustic;
	logic [7:0]  next_acoustic;
	logic        lock;
	logic        next_lock;
	logic [31:0] next_prdata;
	logic [7:0]  word_idx;
	logic        setup;
	logic        access;
	logic        hit_acou;
	logic        hit_lock;
	logic        hit_status;
	logic        miss;
	logic [31:0] read_mux;
	logic [2:0][7:0] applied;

	assign word_idx   = paddr[fan_ramp_pkg::ADDR_W-1:2];
	assign setup      = psel && !penable;
	assign access     = psel && penable;
	assign hit_acou   = (word_idx == fan_ramp_pkg::ACOU_IDX);
	assign hit_lock   = (word_idx == fan_ramp_pkg::LOCK_IDX);
	assign hit_status = (word_idx == fan_ramp_pkg::STATUS_IDX);
	assign miss       = !(hit_acou || hit_lock || hit_status);
	assign pready     = 1'b1;
	assign pslverr    = access && miss;

	always_comb begin
		read_mux = 32'h0000_0000;
		if (hit_acou) begin
			read_mux = {24'h00_0000, acoustic};
		end else if (hit_lock) begin
			read_mux = {31'h0000_0000, lock};
		end else if (hit_status) begin
			read_mux = {8'h00, applied[2], applied[1], applied[0]};
		end
	end

	// Read data captured in setup so it comes from a flop with zero wait states
	always_comb begin
		next_prdata   = prdata;
		next_acoustic = acoustic;
		next_lock     = lock;
		if (setup && !pwrite) begin
			next_prdata = read_mux;
		end
		if (access && pwrite && !lock) begin
			if (hit_acou) begin
				next_acoustic = pwdata[7:0];
			end
			if (hit_lock) begin
				next_lock = pwdata[fan_ramp_pkg::LOCK_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			acoustic <= fan_ramp_pkg::ACOU_RESET;
			lock     <= fan_ramp_pkg::LOCK_RESET;
			prdata   <= 32'h0000_0000;
		end else begin
			acoustic <= next_acoustic;
			lock     <= next_lock;
			prdata   <= next_prdata;
		end
	end

	// ==========================================================
	// Time slot
	logic [31:0] slot_cnt;
	logic [31:0] next_slot_cnt;
	logic        slot_tick;

	// Slot length sets the full ramp time for every rate code
	assign slot_tick = (slot_cnt == 32'(SLOT_CYCLES - 1));

	always_comb begin
		next_slot_cnt = slot_tick ? 32'h0000_0000 : slot_cnt + 32'h0000_0001;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			slot_cnt <= 32'h0000_0000;
		end else begin
			slot_cnt <= next_slot_cnt;
		end
	end

	// ==========================================================
	// Per-channel duty, drive and speed sensing
	logic [2:0]      wave;
	logic [2:0][7:0] target;
	logic [2:0]      sense_pin;
	logic [2:0]      sync1;
	logic [2:0]      sync2;
	logic [2:0]      sync3;
	logic [2:0]      next_sync1;
	logic [2:0]      next_sync2;
	logic [2:0]      next_sync3;
	logic [2:0]      edge_seen;
	logic [2:0]      timed;
	logic [2:0]      next_speed_pulse;

	assign sense_pin = {speed_sense_in4, speed_sense_in3, speed_sense_in2};
	// Input 2 shares output 3 only when aligned; 3 and 4 always do
	assign timed     = {2'b11, acoustic[fan_ramp_pkg::ALIGN_BIT]};

	genvar ch;
	generate
		for (ch = 0; ch < fan_ramp_pkg::CHANNELS; ch++) begin : g_ch
			ramp_if rif ();

			always_comb begin
				target[ch] = computed_duty[ch];
				if (auto_mode && below_threshold[ch]) begin
					target[ch] = acoustic[fan_ramp_pkg::FLOOR_LSB + ch] ?
						minimum_duty[ch] : 8'h00;
				end
			end

			assign rif.slot_tick = slot_tick;
			// Only output 1 has a ramp here; the others load directly
			assign rif.enable    = (ch == 0) ? acoustic[fan_ramp_pkg::EN1_BIT] : 1'b0;
			assign rif.rate      = acoustic[fan_ramp_pkg::RATE_LSB +: fan_ramp_pkg::RATE_W];
			assign rif.target    = target[ch];
			assign applied[ch]   = rif.duty;

			duty_ramp u_ramp (
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.rp      (rif.ramp)
			);

			pwm_wave u_wave (
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.duty    (applied[ch]),
				.wave    (wave[ch])
			);

			assign edge_seen[ch] = sync2[ch] && !sync3[ch];
			always_comb begin
				next_sync1[ch]       = sense_pin[ch];
				next_sync2[ch]       = sync1[ch];
				next_sync3[ch]       = sync2[ch];
				next_speed_pulse[ch] = edge_seen[ch] && (!timed[ch] || wave[2]);
			end
		end
	endgenerate

	// Sense pins idle high; reset to that level so no false edge follows reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1       <= 3'h7;
			sync2       <= 3'h7;
			sync3       <= 3'h7;
			speed_pulse <= 3'h0;
		end else begin
			sync1       <= next_sync1;
			sync2       <= next_sync2;
			sync3       <= next_sync3;
			speed_pulse <= next_speed_pulse;
		end
	end

	assign fan_drive_out1 = wave[0];
	assign fan_drive_out2 = wave[1];
	assign fan_drive_out3 = wave[2];

	// ==========================================================
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence acou_write_s;
		access && pwrite && hit_acou;
	endsequence

	sequence acou_read_s;
		setup && !pwrite && hit_acou ##1 access;
	endsequence

	locked_write_a: assert property (
		acou_write_s and lock |=> acoustic == $past(acoustic))
		else $error("locked register changed");

	ctrl_write_a: assert property (
		acou_write_s and !lock |=> acoustic == $past(pwdata[7:0]))
		else $error("control write lost");

	ctrl_read_a: assert property (
		acou_read_s |-> prdata == {24'h00_0000, acoustic})
		else $error("control read wrong");

	slot_period_a: assert property (
		slot_tick |=> !slot_tick [*2])
		else $error("time slot too short");

	out1_direct_a: assert property (
		!acoustic[fan_ramp_pkg::EN1_BIT] |=> applied[0] == $past(target[0]))
		else $error("output 1 ramped while disabled");

	floor_out1_a: assert property (
		auto_mode && below_threshold[0] |-> target[0] ==
			(acoustic[fan_ramp_pkg::FLOOR_LSB] ? minimum_duty[0] : 8'h00))
		else $error("output 1 floor duty wrong");

	floor_out2_a: assert property (
		auto_mode && below_threshold[1] |-> target[1] ==
			(acoustic[fan_ramp_pkg::FLOOR_LSB + 1] ? minimum_duty[1] : 8'h00))
		else $error("output 2 floor duty wrong");

	floor_out3_a: assert property (
		auto_mode && below_threshold[2] |-> target[2] ==
			(acoustic[fan_ramp_pkg::FLOOR_LSB + 2] ? minimum_duty[2] : 8'h00))
		else $error("output 3 floor duty wrong");

	aligned_gate_a: assert property (
		edge_seen[0] && acoustic[fan_ramp_pkg::ALIGN_BIT] && !fan_drive_out3
		|=> !speed_pulse[0])
		else $error("aligned input 2 counted while output 3 off");

	free_input2_a: assert property (
		edge_seen[0] && !acoustic[fan_ramp_pkg::ALIGN_BIT] |=> speed_pulse[0])
		else $error("unaligned input 2 edge dropped");

	gate_in3_a: assert property (
		edge_seen[1] && !fan_drive_out3 |=> !speed_pulse[1])
		else $error("input 3 counted while output 3 off");

	gate_in4_a: assert property (
		edge_seen[2] && !fan_drive_out3 |=> !speed_pulse[2])
		else $error("input 4 counted while output 3 off");

	aligned_pass_a: assert property (
		edge_seen[0] && acoustic[fan_ramp_pkg::ALIGN_BIT] && fan_drive_out3
		|=> speed_pulse[0])
		else $error("aligned input 2 edge dropped while output 3 on");

	lock_sticky_a: assert property (
		lock |=> lock)
		else $error("lock bit cleared");

	out1_hold_a: assert property (
		acoustic[fan_ramp_pkg::EN1_BIT] && !slot_tick |=> $stable(applied[0]))
		else $error("output 1 moved outside a time slot");

	out1_climb_a: assert property (
		acoustic[fan_ramp_pkg::EN1_BIT] && slot_tick && target[0] > applied[0]
		|=> applied[0] > $past(applied[0]) && applied[0] <= $past(target[0]))
		else $error("output 1 ramp step wrong");

	others_direct_a: assert property (
		rstn |=> applied[1] == $past(target[1]) && applied[2] == $past(target[2]))
		else $error("outputs 2 and 3 not loaded directly");

endmodule : fan_ramp_ctrl

`default_nettype wire

// *** tb/fan_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module fan_model (
	// Clock and run control
	input  wire logic sys_clk,
	input  wire logic spin,
	// Sense lines back to the device
	output logic      speed_sense_in2,
	output logic      speed_sense_in3,
	output logic      speed_sense_in4
);
	int cnt;

	// ==========================================================
	// Rotor pulses
	// Pulled-up sense lines sit high while the rotor stands still
	initial begin
		cnt = 0;
		speed_sense_in2 = 1'b1;
		speed_sense_in3 = 1'b1;
		speed_sense_in4 = 1'b1;
	end
	// Falling edge keeps pin changes clear of the device's sampling edge
	always @(negedge sys_clk) begin
		cnt <= cnt + 1;
		speed_sense_in2 <= spin ? cnt[2] : 1'b1;
		speed_sense_in3 <= spin ? cnt[3] : 1'b1;
		speed_sense_in4 <= spin ? cnt[2] ^ cnt[4] : 1'b1;
	end
endmodule : fan_model

`default_nettype wire

// *** tb/tb_fan_ramp_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_fan_ramp_ctrl;
	localparam logic [9:0] CTRL = {fan_ramp_pkg::ACOU_IDX, 2'b00};
	localparam logic [9:0] LOCK = {fan_ramp_pkg::LOCK_IDX, 2'b00};
	localparam logic [9:0] STAT = {fan_ramp_pkg::STATUS_IDX, 2'b00};
	localparam logic [9:0] BAD  = 10'h3fc;
	logic            sys_clk = 1'b0;
	logic            rstn = 1'b0;
	logic            psel = 1'b0;
	logic            penable = 1'b0;
	logic            pwrite = 1'b0;
	logic [9:0]      paddr = 10'h000;
	logic [31:0]     pwdata = 32'h0;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	logic            auto_mode = 1'b0;
	logic [2:0]      below_threshold = 3'h0;
	logic [2:0][7:0] computed_duty = '0;
	logic [2:0][7:0] minimum_duty = '0;
	logic            spin = 1'b0;
	logic            s2;
	logic            s3;
	logic            s4;
	logic [2:0]      speed_pulse;
	logic [2:0]      seen;
	logic [31:0]     seed = 32'h1c0d7095;
	logic [31:0]     rdat;
	logic [7:0]      v;
	logic [32:0]     exp_q [$];
	logic [32:0]     msk_q [$];
	logic [7:0]      steps [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
	int              num_errors = 0;
	int              checks = 0;
	logic [2:0]      drv;
	int              high_cnt [3];

	always #50 sys_clk = ~sys_clk;

	fan_ramp_ctrl #(.SLOT_CYCLES(8)) i_dut (
		.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.auto_mode(auto_mode), .below_threshold(below_threshold),
		.computed_duty(computed_duty), .minimum_duty(minimum_duty),
		.speed_sense_in2(s2), .speed_sense_in3(s3), .speed_sense_in4(s4),
		.fan_drive_out1(drv[0]), .fan_drive_out2(drv[1]), .fan_drive_out3(drv[2]),
		.speed_pulse(speed_pulse)
	);

	fan_model i_fan (
		.sys_clk(sys_clk), .spin(spin),
		.speed_sense_in2(s2), .speed_sense_in3(s3), .speed_sense_in4(s4)
	);

	// ==========================================================
	// Checking
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// Zero mask marks a poll read whose value the driver judges itself
	always @(posedge sys_clk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			if (msk_q[0] != 33'h0)
				chk({pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		num_errors++;
		wrap_up();
	end

	// ==========================================================
	// APB master
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
			input logic [32:0] e, input logic [32:0] m);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
		end
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			wrap_up();
		end
	endtask : apb

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d}, 33'h0, 33'h0);
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0, e, {33{1'b1}});
	endtask : rd

	// Bounded poll until the applied out1 duty leaves its old value
	task automatic poll(input logic [7:0] old);
		int n;
		n = 0;
		do begin
			apb(1'b0, STAT, 32'h0, 33'h0, 33'h0);
			n++;
		end while (rdat[7:0] === old && n < 30);
		if (n >= 30) begin
			num_errors++;
			wrap_up();
		end
	endtask : poll

	// ==========================================================
	// Scenarios
	initial begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(CTRL, 33'h0);
		rd(BAD, {1'b1, 32'h0});
		seed = lfsr(seed);
		wr(CTRL, seed[7:0]);
		rd(CTRL, {25'h0, seed[7:0]});
		wr(CTRL, 8'h07);
		for (int t = 0; t < 3; t++) begin
			seed = lfsr(seed);
			computed_duty <= seed[23:0];
			repeat (3) @(posedge sys_clk);
			rd(STAT, {9'h0, seed[23:0]});
		end
		auto_mode <= 1'b1;
		below_threshold <= 3'b111;
		for (int f = 0; f < 8; f++) begin
			seed = lfsr(seed);
			minimum_duty <= seed[23:0];
			wr(CTRL, 8'(f << 5));
			repeat (3) @(posedge sys_clk);
			rd(STAT, {9'h0, f[2] ? seed[23:16] : 8'h0, f[1] ? seed[15:8] : 8'h0,
				f[0] ? seed[7:0] : 8'h0});
		end
		auto_mode <= 1'b0;
		below_threshold <= 3'b000;
		computed_duty <= '0;
		for (int r = 0; r < 8; r++) begin
			wr(CTRL, 8'h00);
			computed_duty[0] <= 8'h20;
			repeat (3) @(posedge sys_clk);
			wr(CTRL, 8'h08 | 8'(r));
			computed_duty[0] <= 8'hff;
			v = 8'h20;
			for (int k = 0; k < 2; k++) begin
				poll(v);
				chk({25'h0, rdat[7:0]}, {25'h0, v + steps[r]});
				v = rdat[7:0];
			end
		end
		computed_duty[0] <= v + 8'h01;
		poll(v);
		chk({25'h0, rdat[7:0]}, {25'h0, v + 8'h01});
		// Ramp down at code 7 until clamped at the new target
		computed_duty[0] <= 8'h10;
		for (int k = 0; k < 3; k++) begin
			v = rdat[7:0];
			poll(v);
			chk({25'h0, rdat[7:0]}, {25'h0, (v > 8'h40) ? v - 8'h30 : 8'h10});
		end
		wr(CTRL, 8'h00);
		spin <= 1'b1;
		for (int a = 0; a < 2; a++) begin
			wr(CTRL, 8'(a << 4));
			seen = 3'h0;
			repeat (400) @(posedge sys_clk) seen = seen | speed_pulse;
			chk({30'h0, seen}, {30'h0, 1'b0, 1'b0, a == 0});
		end
		computed_duty[2] <= 8'hff;
		repeat (11000) @(posedge sys_clk);
		seen = 3'h0;
		repeat (400) @(posedge sys_clk) seen = seen | speed_pulse;
		chk({30'h0, seen}, {30'h0, 3'b111});
		// One whole drive period: high cycles follow the applied duties
		high_cnt = '{0, 0, 0};
		repeat (256 * (int'(fan_ramp_pkg::PWM_PRESCALE) + 1)) begin
			@(posedge sys_clk);
			foreach (high_cnt[i]) high_cnt[i] += int'(drv[i]);
		end
		chk(33'(high_cnt[0]), 33'(16 * (int'(fan_ramp_pkg::PWM_PRESCALE) + 1)));
		chk(33'(high_cnt[1]), 33'h0);
		chk(33'(high_cnt[2]), 33'(255 * (int'(fan_ramp_pkg::PWM_PRESCALE) + 1)));
		wr(CTRL, 8'h3c);
		wr(LOCK, 8'h01);
		rd(LOCK, 33'h1);
		wr(LOCK, 8'h00);
		rd(LOCK, 33'h1);
		wr(CTRL, 8'hc3);
		rd(CTRL, 33'h3c);
		wrap_up();
	end
endmodule : tb_fan_ramp_ctrl

`default_nettype wire
